//--- design/fbe_pkg.sv
// package: event codes, qualifiers, decoder timing and carrier structs for the event selector
package fbe_pkg;

    localparam int          EVT_W             = 8;
    localparam int          UMASK_W           = 8;
    localparam logic [7:0]  EVT_ITB           = 8'h82;
    localparam logic [7:0]  EVT_QUEUE_FULL    = 8'h83;
    localparam logic [7:0]  EVT_FETCH_STALL   = 8'h86;
    localparam logic [7:0]  EVT_SLOW_DECODE   = 8'h87;
    localparam logic [7:0]  EVT_BR_EXEC       = 8'h88;
    localparam logic [7:0]  EVT_BR_MISP       = 8'h89;
    localparam logic [7:0]  EVT_BR_DEC_MISP   = 8'h8A;
    localparam logic [7:0]  EVT_CND_EXEC      = 8'h8B;
    localparam logic [7:0]  EVT_CND_MISP      = 8'h8C;
    localparam logic [7:0]  EVT_IND_EXEC      = 8'h8D;
    localparam logic [7:0]  UM_ITB_FLUSH      = 8'h40;
    localparam logic [7:0]  UM_ITB_MISS       = 8'h12;
    localparam logic [7:0]  UM_QUEUE_FULL     = 8'h02;
    localparam logic [7:0]  UM_NONE           = 8'h00;
    localparam logic [7:0]  OPSIZE_PREFIX     = 8'h66;
    localparam logic [7:0]  ADDRSIZE_PREFIX   = 8'h67;
    localparam int          SLOW_DECODE_CYC   = 6;
    localparam logic [2:0]  SLOW_CNT_LAST     = 3'(SLOW_DECODE_CYC - 1);
    localparam logic [2:0]  SLOW_CNT_RESET    = 3'h0;

    // cpu operating modes for the address-size check
    localparam logic [2:0]  MODE_REAL         = 3'h0;
    localparam logic [2:0]  MODE_BIG_REAL     = 3'h1;
    localparam logic [2:0]  MODE_PROT16       = 3'h2;
    localparam logic [2:0]  MODE_PROT32       = 3'h3;
    localparam logic [2:0]  MODE_LONG64       = 3'h4;

    typedef struct packed {
        logic [EVT_W-1:0]   event_num;
        logic [UMASK_W-1:0] umask;
    } fbe_select_t;

    typedef struct packed {
        logic itb_flush;
        logic itb_miss_small;
        logic itb_miss_large;
        logic fetch_queue_full;
        logic fetch_stall;
    } fbe_fetch_t;

    // one instruction handed to the length decoder
    typedef struct packed {
        logic       valid;
        logic [7:0] prefix;
        logic       has_prefix;
        logic       has_imm;
        logic       has_modrm;
        logic [2:0] cpu_mode;
    } fbe_decode_t;

    typedef struct packed {
        logic br_exec;
        logic br_misp;
        logic br_uop;
        logic br_dec_misp;
        logic br_cond;
        logic br_indirect;
    } fbe_branch_t;

    typedef enum logic [1:0] {
        LD_FAST = 2'b01,
        LD_SLOW = 2'b10
    } fbe_ld_state_t;

endpackage

//--- design/fbe_event_selector.sv
// front-end and branch performance event selector with instruction length decoder timing
`timescale 1ns/1ps
module fbe_event_selector (
    input  wire logic                 mclk_in,
    input  wire logic                 reset_n_in,
    input  wire fbe_pkg::fbe_select_t select_in,
    input  wire fbe_pkg::fbe_fetch_t  fetch_in,
    input  wire fbe_pkg::fbe_decode_t decode_in,
    input  wire fbe_pkg::fbe_branch_t branch_in,
    output logic                      increment_out,
    output logic                      select_valid_out,
    output logic                      fetch_enable_out,
    output logic                      decode_ready_out,
    output logic                      decode_done_out,
    output logic                      slow_decode_out
);
    import fbe_pkg::*;

    // ****************************************************************
    // length decoder timing
    // ****************************************************************
    fbe_ld_state_t ld_state_q;
    fbe_ld_state_t ld_state_d;
    logic [2:0]    slow_cnt_q;
    logic [2:0]    slow_cnt_d;
    logic          done_q;
    logic          done_d;
    logic          need_slow;
    logic          legacy_mode;
    logic          op_slow;
    logic          addr_slow;

    // ****************************************************************
    // slow path detection
    // ****************************************************************

    // a size prefix that changes the instruction length forces the slow path;
    // the address-size case only matters outside 64-bit mode
    always_comb begin
        case (decode_in.cpu_mode)
            MODE_REAL:     legacy_mode = 1'b1;
            MODE_BIG_REAL: legacy_mode = 1'b1;
            MODE_PROT16:   legacy_mode = 1'b1;
            MODE_PROT32:   legacy_mode = 1'b1;
            MODE_LONG64:   legacy_mode = 1'b0;
            default:       legacy_mode = 1'b0;
        endcase
        op_slow   = decode_in.has_prefix && (decode_in.prefix == OPSIZE_PREFIX)
                 && decode_in.has_imm;
        addr_slow = decode_in.has_prefix && (decode_in.prefix == ADDRSIZE_PREFIX)
                 && decode_in.has_modrm && legacy_mode;
        need_slow = op_slow || addr_slow;
    end

    // an offer made while the slow path runs is ignored; the core must hold
    // it until decode_ready_out returns
    always_comb begin
        ld_state_d = ld_state_q;
        slow_cnt_d = slow_cnt_q;
        done_d     = 1'b0;
        case (ld_state_q)
            LD_FAST: begin
                if (decode_in.valid) begin
                    if (need_slow) begin
                        ld_state_d = LD_SLOW;
                        slow_cnt_d = SLOW_CNT_RESET;
                    end else begin
                        done_d = 1'b1;
                    end
                end
            end
            LD_SLOW: begin
                if (slow_cnt_q == SLOW_CNT_LAST) begin
                    ld_state_d = LD_FAST;
                    done_d     = 1'b1;
                end else begin
                    slow_cnt_d = slow_cnt_q + 3'h1;
                end
            end
            default: begin
                ld_state_d = LD_FAST;
                slow_cnt_d = SLOW_CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ld_state_q <= LD_FAST;
            slow_cnt_q <= SLOW_CNT_RESET;
            done_q     <= 1'b0;
        end else begin
            ld_state_q <= ld_state_d;
            slow_cnt_q <= slow_cnt_d;
            done_q     <= done_d;
        end
    end

    // slow path busy in the six cycles of a slow instruction
    logic slow_active;
    assign slow_active = (ld_state_q == LD_SLOW);

    // ****************************************************************
    // event match
    // ****************************************************************
    logic hit;
    logic match;
    logic cond_itb_flush;
    logic cond_itb_miss;
    logic cond_queue_full;
    logic cond_fetch_stall;
    logic cond_slow_decode;
    logic cond_br_exec;
    logic cond_br_misp;
    logic cond_br_dec_misp;
    logic cond_cnd_exec;
    logic cond_cnd_misp;
    logic cond_ind_exec;

    // level events count every cycle they stand, pulse events once per pulse
    always_comb begin
        cond_itb_flush   = fetch_in.itb_flush;
        cond_itb_miss    = fetch_in.itb_miss_small || fetch_in.itb_miss_large;
        cond_queue_full  = fetch_in.fetch_queue_full;
        cond_fetch_stall = fetch_in.fetch_stall;
        cond_slow_decode = slow_active;
    end

    // branch qualifiers other than br_dec_misp only mean something while br_exec is high; br_dec_misp counts on its own
    always_comb begin
        cond_br_exec     = branch_in.br_exec && !branch_in.br_uop;
        cond_br_misp     = branch_in.br_exec && branch_in.br_misp;
        cond_br_dec_misp = branch_in.br_dec_misp;
        cond_cnd_exec    = branch_in.br_exec && branch_in.br_cond;
        cond_cnd_misp    = cond_cnd_exec && branch_in.br_misp;
        cond_ind_exec    = branch_in.br_exec && branch_in.br_indirect;
    end

    // both the event number and the qualifier must name a defined encoding
    always_comb begin
        hit   = 1'b0;
        match = 1'b0;
        case (select_in.event_num)
            EVT_ITB: begin
                if (select_in.umask == UM_ITB_FLUSH) begin
                    match = 1'b1;
                    hit   = cond_itb_flush;
                end else if (select_in.umask == UM_ITB_MISS) begin
                    match = 1'b1;
                    hit   = cond_itb_miss;
                end
            end
            EVT_QUEUE_FULL: begin
                if (select_in.umask == UM_QUEUE_FULL) begin
                    match = 1'b1;
                    hit   = cond_queue_full;
                end
            end
            EVT_FETCH_STALL: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_fetch_stall;
                end
            end
            EVT_SLOW_DECODE: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_slow_decode;
                end
            end
            EVT_BR_EXEC: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_br_exec;
                end
            end
            EVT_BR_MISP: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_br_misp;
                end
            end
            EVT_BR_DEC_MISP: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_br_dec_misp;
                end
            end
            EVT_CND_EXEC: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_cnd_exec;
                end
            end
            EVT_CND_MISP: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_cnd_misp;
                end
            end
            EVT_IND_EXEC: begin
                if (select_in.umask == UM_NONE) begin
                    match = 1'b1;
                    hit   = cond_ind_exec;
                end
            end
            default: begin
                match = 1'b0;
                hit   = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // counter-side output registers
    // ****************************************************************

    logic inc_q;
    logic inc_d;
    logic valid_q;
    logic valid_d;
    logic fetch_en_q;
    logic fetch_en_d;

    // one pulse per counted event, or per cycle of a level event
    always_comb begin
        inc_d      = match && hit;
        valid_d    = match;
        fetch_en_d = !fetch_in.fetch_queue_full;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            inc_q      <= 1'b0;
            valid_q    <= 1'b0;
            fetch_en_q <= 1'b0;
        end else begin
            inc_q      <= inc_d;
            valid_q    <= valid_d;
            fetch_en_q <= fetch_en_d;
        end
    end

    // ****************************************************************
    // decoder-side output registers
    // ****************************************************************

    logic ready_q;
    logic ready_d;
    logic slow_q;
    logic slow_d;

    // both follow the state the decoder enters at this edge
    always_comb begin
        ready_d = (ld_state_d == LD_FAST);
        slow_d  = (ld_state_d == LD_SLOW);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_q <= 1'b0;
            slow_q  <= 1'b0;
        end else begin
            ready_q <= ready_d;
            slow_q  <= slow_d;
        end
    end

    assign increment_out    = inc_q;
    assign select_valid_out = valid_q;
    assign fetch_enable_out = fetch_en_q;
    assign decode_ready_out = ready_q;
    assign decode_done_out  = done_q;
    assign slow_decode_out  = slow_q;

endmodule

//--- testbench/fbe_event_selector_asserts.sv
// checker: output timing of the event selector
`timescale 1ns/1ps
module fbe_event_selector_asserts (
    input wire logic                 mclk_in,
    input wire logic                 reset_n_in,
    input wire fbe_pkg::fbe_select_t select_in,
    input wire fbe_pkg::fbe_fetch_t  fetch_in,
    input wire fbe_pkg::fbe_decode_t decode_in,
    input wire fbe_pkg::fbe_branch_t branch_in,
    input wire logic                 increment_out,
    input wire logic                 select_valid_out,
    input wire logic                 fetch_enable_out,
    input wire logic                 decode_ready_out,
    input wire logic                 decode_done_out,
    input wire logic                 slow_decode_out
);
    import fbe_pkg::*;
    default clocking dcb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic slow_hit;
    assign slow_hit = decode_in.valid && decode_ready_out && decode_in.has_prefix
        && ((decode_in.prefix == 8'h66 && decode_in.has_imm) || (decode_in.prefix == 8'h67
        && decode_in.has_modrm && decode_in.cpu_mode <= 3'h3));
    sequence slow_run_s;
        slow_decode_out [*6] ##1 (decode_done_out && decode_ready_out);
    endsequence
    itb_flush_a:
        assert property (select_in == 16'h8240 && fetch_in.itb_flush |=> increment_out)
        else $error("flush not counted");
    itb_miss_a:
        assert property (select_in == 16'h8212 && (fetch_in.itb_miss_small
            || fetch_in.itb_miss_large) |=> increment_out)
        else $error("miss not counted");
    fetch_halt_a:
        assert property (fetch_in.fetch_queue_full |=> !fetch_enable_out)
        else $error("fetch not halted");
    stall_count_a:
        assert property (select_in == 16'h8600 && fetch_in.fetch_stall |=> increment_out)
        else $error("stall not counted");
    slow_len_a:
        assert property (slow_hit |=> slow_run_s)
        else $error("slow decode length wrong");
    slow_count_a:
        assert property (select_in == 16'h8700 && slow_decode_out |=> increment_out)
        else $error("slow cycle not counted");
    branch_exec_a:
        assert property (select_in == 16'h8800 && branch_in.br_exec
            && !branch_in.br_uop |=> increment_out)
        else $error("branch not counted");
    no_match_a:
        assert property (!select_valid_out |-> !increment_out)
        else $error("count on undefined select");
endmodule

bind fbe_event_selector fbe_event_selector_asserts i_chk (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .select_in(select_in),
    .fetch_in(fetch_in), .decode_in(decode_in), .branch_in(branch_in),
    .increment_out(increment_out), .select_valid_out(select_valid_out),
    .fetch_enable_out(fetch_enable_out), .decode_ready_out(decode_ready_out),
    .decode_done_out(decode_done_out), .slow_decode_out(slow_decode_out)
);

//--- testbench/fbe_core_model.sv
// core model: fetch, decode and branch strobes made from a random word
`timescale 1ns/1ps
module fbe_core_model (
    input  wire logic [31:0]     rnd_in,
    input  wire logic            mclk_in,
    output fbe_pkg::fbe_fetch_t  fetch_out,
    output fbe_pkg::fbe_decode_t decode_out,
    output fbe_pkg::fbe_branch_t branch_out
);
    import fbe_pkg::*;
    initial begin
        fetch_out = '0;
        decode_out = '0;
        branch_out = '0;
    end
    // prefixes biased towards the two length-changing ones
    always @(negedge mclk_in) begin
        fetch_out <= rnd_in[4:0];
        decode_out.valid <= rnd_in[5];
        decode_out.prefix <= rnd_in[6] ? (rnd_in[7] ? 8'h66 : 8'h67) : rnd_in[15:8];
        decode_out.has_prefix <= rnd_in[16] | rnd_in[17];
        decode_out.has_imm <= rnd_in[18];
        decode_out.has_modrm <= rnd_in[19];
        decode_out.cpu_mode <= rnd_in[22] ? MODE_LONG64 : {1'b0, rnd_in[21:20]};
        branch_out <= rnd_in[28:23];
    end
endmodule

//--- testbench/fbe_event_selector_tb_top.sv
// testbench: random core traffic against a behavioural model of the selector
`timescale 1ns/1ps
module fbe_event_selector_tb_top;
    import fbe_pkg::*;
    logic        mclk_in;
    logic        reset_n_in;
    fbe_select_t select_in;
    fbe_fetch_t  fetch_in;
    fbe_decode_t decode_in;
    fbe_branch_t branch_in;
    logic        inc, sval, fen, rdy, done, slow;
    logic        e_inc, e_sval, e_fen, e_rdy, e_done;
    logic [31:0] rnd;
    int          miscompares, checks, cnt, cycles;
    fbe_select_t sels [18] = '{16'h8240, 16'h8212, 16'h8302, 16'h8600, 16'h8700, 16'h8800,
        16'h8900, 16'h8A00, 16'h8B00, 16'h8C00, 16'h8D00, 16'h8202, 16'h8210, 16'h8301,
        16'h8601, 16'h8E00, 16'h875A, 16'h8DFF};

    fbe_event_selector i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .select_in(select_in), .fetch_in(fetch_in), .decode_in(decode_in),
        .branch_in(branch_in), .increment_out(inc), .select_valid_out(sval),
        .fetch_enable_out(fen), .decode_ready_out(rdy), .decode_done_out(done),
        .slow_decode_out(slow));
    fbe_core_model i_core (.rnd_in(rnd), .mclk_in(mclk_in), .fetch_out(fetch_in),
        .decode_out(decode_in), .branch_out(branch_in));

    function automatic logic slow_c(fbe_decode_t d);
        return d.has_prefix && ((d.prefix == 8'h66 && d.has_imm)
            || (d.prefix == 8'h67 && d.has_modrm && d.cpu_mode <= 3'h3));
    endfunction
    function automatic logic hit(fbe_select_t s, int c);
        fbe_branch_t b;
        b = branch_in;
        case (s)
            16'h8240: return fetch_in.itb_flush;
            16'h8212: return fetch_in.itb_miss_small | fetch_in.itb_miss_large;
            16'h8302: return fetch_in.fetch_queue_full;
            16'h8600: return fetch_in.fetch_stall;
            16'h8700: return c != 0;
            16'h8800: return b.br_exec & !b.br_uop;
            16'h8900: return b.br_exec & b.br_misp;
            16'h8A00: return b.br_dec_misp;
            16'h8B00: return b.br_exec & b.br_cond;
            16'h8C00: return b.br_exec & b.br_cond & b.br_misp;
            16'h8D00: return b.br_exec & b.br_indirect;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(string n, logic got, logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    function automatic logic [31:0] xorshift(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    always @(negedge mclk_in) begin
        rnd <= xorshift(rnd);
    end
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {cnt, e_inc, e_sval, e_fen, e_rdy, e_done} = '0;
        end else begin
            e_inc = hit(select_in, cnt);
            e_sval = select_in inside {16'h8240, 16'h8212, 16'h8302, 16'h8600}
                || (select_in.event_num inside {[8'h87:8'h8D]} && select_in.umask == 8'h00);
            e_fen = !fetch_in.fetch_queue_full;
            e_done = (cnt == 0 && decode_in.valid && !slow_c(decode_in)) || cnt == 1;
            cnt = cnt != 0 ? cnt - 1 : ((decode_in.valid && slow_c(decode_in)) ? 6 : 0);
            e_rdy = cnt == 0;
        end
    end
    always @(negedge mclk_in) begin
        #1;
        chk("increment", inc, e_inc);
        chk("select_valid", sval, e_sval);
        chk("fetch_enable", fen, e_fen);
        chk("decode_ready", rdy, e_rdy);
        chk("decode_done", done, e_done);
        chk("slow_decode", slow, cnt != 0);
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        {miscompares, checks, cycles} = '0;
        rnd = 32'h0000_88E7;
        select_in = '0;
        reset_n_in = 1'b0;
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in) reset_n_in = 1'b1;
        foreach (sels[i]) begin
            @(negedge mclk_in) select_in = sels[i];
            repeat (300) @(negedge mclk_in);
            if (i == 4) begin
                reset_n_in = 1'b0;
                repeat (3) @(negedge mclk_in);
                reset_n_in = 1'b1;
            end
            $display("test select %h done, miscompares %0d", sels[i], miscompares);
        end
        wrap_up();
    end
endmodule
